// >>> design/qpsd_cfg.svh
// Constants of the quad potentiometer serial command decoder
`ifndef QPSD_CFG_SVH
`define QPSD_CFG_SVH

// ----------------------------------------------------------------------
// Identification byte
// ----------------------------------------------------------------------
`define QPSD_ID_TYPE 4'h5
`define QPSD_ID_ZERO 2'h0

// ----------------------------------------------------------------------
// Instruction opcodes (upper nibble of the instruction byte)
// ----------------------------------------------------------------------
`define QPSD_OP_RD_WIPER 4'h9
`define QPSD_OP_WR_WIPER 4'ha
`define QPSD_OP_RD_SLOT 4'hb
`define QPSD_OP_WR_SLOT 4'hc
`define QPSD_OP_SLOT_TO_WIPER 4'hd
`define QPSD_OP_WIPER_TO_SLOT 4'he
`define QPSD_OP_GLB_SLOT_TO_WIPER 4'h1
`define QPSD_OP_GLB_WIPER_TO_SLOT 4'h8
`define QPSD_OP_STEP 4'h2
`define QPSD_OP_STATUS 4'h5

// ----------------------------------------------------------------------
// Fixed low-nibble fields and status byte padding
// ----------------------------------------------------------------------
`define QPSD_STATUS_LOW 4'h1
`define QPSD_ZERO_SLOT 2'h0
`define QPSD_ZERO_CHAN 2'h0
`define QPSD_STATUS_PAD 7'h00

// ----------------------------------------------------------------------
// Register limits and reset values
// ----------------------------------------------------------------------
`define QPSD_WIPER_RST 8'h00
`define QPSD_SLOT_RST 8'h00
`define QPSD_WIPER_MAX 8'hff
`define QPSD_WIPER_MIN 8'h00
`define QPSD_BIT_LAST 3'h7

// ----------------------------------------------------------------------
// Nonvolatile write timing
// ----------------------------------------------------------------------
`define QPSD_NV_WRITE_US 5000
`define QPSD_CLK_MHZ 100

`endif

// >>> design/qpsd_pkg.sv
// Types shared by the quad potentiometer serial command decoder
package qpsd_pkg;

   // ----------------------------------------------------------------------
   // Frame states of the serial decoder
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      QPSD_ST_ID = 3'b000,
      QPSD_ST_INSTR = 3'b001,
      QPSD_ST_DATA = 3'b010,
      QPSD_ST_STEP = 3'b011,
      QPSD_ST_IGNORE = 3'b100,
      QPSD_ST_DONE = 3'b101
   } qpsd_state_t;

   // ----------------------------------------------------------------------
   // Kind of third byte
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      QPSD_DK_READ = 2'b00,
      QPSD_DK_WR_WIPER = 2'b01,
      QPSD_DK_WR_SLOT = 2'b10
   } qpsd_dkind_t;

endpackage

// >>> design/qpsd_nv_timer.sv
// Nonvolatile write cycle timer on the system clock
`include "qpsd_cfg.svh"

module qpsd_nv_timer
   import qpsd_pkg::*;
#(
   parameter int unsigned NV_WRITE_CYCLES = `QPSD_NV_WRITE_US * `QPSD_CLK_MHZ
) (
   // System clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Frame pin and request toggle from the serial domain
   input wire logic cs_n_in,
   input wire logic req_tgl_in,
   // Write cycle running
   output logic busy_out
);

   localparam int unsigned CW = $clog2(NV_WRITE_CYCLES + 1);

   logic cs_meta_r;  // First stage of chip select synchroniser
   logic cs_sync_r;  // Chip select seen on clk_in
   logic tgl_meta_r;  // First stage of request synchroniser
   logic tgl_sync_r;  // Request toggle seen on clk_in
   logic tgl_seen_r;  // Last request already served
   logic busy_r;  // Write cycle running
   logic [CW-1:0] cnt_r;  // Cycles spent in the write cycle
   logic start;  // Begin a write cycle

   // ----------------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------------
   // Two flops each for the frame pin and the request toggle
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cs_meta_r <= 1'b1;
         cs_sync_r <= 1'b1;
         tgl_meta_r <= 1'b0;
         tgl_sync_r <= 1'b0;
      end else begin
         cs_meta_r <= cs_n_in;
         cs_sync_r <= cs_meta_r;
         tgl_meta_r <= req_tgl_in;
         tgl_sync_r <= tgl_meta_r;
      end
   end

   // A pending request starts once chip select is back high
   assign start = cs_sync_r && (tgl_sync_r != tgl_seen_r) && !busy_r;

   // ----------------------------------------------------------------------
   // Write cycle
   // ----------------------------------------------------------------------
   // Busy holds for the full write time, then clears
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tgl_seen_r <= 1'b0;
         busy_r <= 1'b0;
         cnt_r <= '0;
      end else if (start) begin
         tgl_seen_r <= tgl_sync_r;
         busy_r <= 1'b1;
         cnt_r <= '0;
      end else if (busy_r) begin
         if (cnt_r == CW'(NV_WRITE_CYCLES - 1)) begin
            busy_r <= 1'b0;
         end else begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end

   assign busy_out = busy_r;

endmodule

// >>> design/qpsd_spi_decoder.sv
// Serial command decoder of a four channel digital potentiometer
`include "qpsd_cfg.svh"

module qpsd_spi_decoder
   import qpsd_pkg::*;
#(
   parameter int unsigned NCH = 4,
   parameter int unsigned NV_WRITE_CYCLES = `QPSD_NV_WRITE_US * `QPSD_CLK_MHZ
) (
   // System clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Serial link
   input wire logic sck_in,
   input wire logic cs_n_in,
   input wire logic si_in,
   output logic so_out,
   output logic so_oe_out,
   // Address straps
   input wire logic chip_addr_hi_in,
   input wire logic chip_addr_lo_in,
   // Wiper positions, channel 0 in the low byte
   output logic [NCH*8-1:0] wiper_position_reg_out,
   // Nonvolatile write running
   output logic nv_write_busy_out
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic frame_rst;  // Idle frame or system reset
   qpsd_state_t state_r;  // Frame state
   qpsd_state_t state_nxt;  // Next frame state
   qpsd_dkind_t dkind_r;  // Kind of third byte
   qpsd_dkind_t dkind_nxt;  // Next kind of third byte
   logic [2:0] bit_r;  // Bit position inside the byte
   logic [6:0] shift_r;  // Received bits so far
   logic [7:0] instr_r;  // Latched instruction byte
   logic [7:0] tx_r;  // Outgoing byte, MSB leads
   logic [7:0] tx_nxt;  // Outgoing byte to load
   logic tx_load;  // Load outgoing byte
   logic byte_done;  // Eighth bit arrives at this edge
   logic [7:0] rx_byte;  // Whole byte including the current bit
   logic so_r;  // Serial output bit
   logic so_oe_r;  // Serial output driven
   logic addr_meta_r [2];  // First stage of strap synchroniser
   logic [1:0] addr_sync_r;  // Straps seen on the serial clock
   logic busy_meta_r;  // First stage of busy synchroniser
   logic busy_sync_r;  // Busy seen on the serial clock
   logic busy;  // Busy from the write timer
   logic nv_req_tgl_r;  // Toggles for each nonvolatile write
   logic nv_req;  // A write sequence completed here
   logic [7:0] wiper_r [NCH];  // Wiper position registers
   logic [7:0] slot_r [NCH*4];  // Saved setting slots
   logic [NCH-1:0] wip_we;  // Per channel wiper write
   logic [7:0] wip_wd [NCH];  // Per channel wiper data
   logic [NCH-1:0] slot_we;  // Per channel slot write
   logic [1:0] slot_sel;  // Slot written
   logic [7:0] slot_wd [NCH];  // Per channel slot data
   logic [1:0] chan;  // Channel field of the instruction
   logic [1:0] rslot;  // Slot field of the instruction
   logic [1:0] rx_chan;  // Channel field of the byte arriving
   logic [1:0] rx_slot;  // Slot field of the byte arriving

   // The frame logic restarts whenever chip select is high
   assign frame_rst = rst_in | cs_n_in;

   assign byte_done = (bit_r == `QPSD_BIT_LAST);
   assign rx_byte = {shift_r, si_in};
   assign chan = instr_r[1:0];
   assign rslot = instr_r[3:2];
   assign rx_chan = rx_byte[1:0];
   assign rx_slot = rx_byte[3:2];

   // ----------------------------------------------------------------------
   // Synchronisers into the serial clock domain
   // ----------------------------------------------------------------------
   // Straps and busy pass two flops before the decoder reads them
   always_ff @(posedge sck_in or posedge rst_in) begin
      if (rst_in) begin
         addr_meta_r[0] <= 1'b0;
         addr_meta_r[1] <= 1'b0;
         addr_sync_r <= 2'h0;
         busy_meta_r <= 1'b0;
         busy_sync_r <= 1'b0;
      end else begin
         addr_meta_r[0] <= chip_addr_lo_in;
         addr_meta_r[1] <= chip_addr_hi_in;
         addr_sync_r <= {addr_meta_r[1], addr_meta_r[0]};
         busy_meta_r <= busy;
         busy_sync_r <= busy_meta_r;
      end
   end

   // ----------------------------------------------------------------------
   // Bit counter and receive shifter
   // ----------------------------------------------------------------------
   // Data is sampled on the rising serial clock edge
   always_ff @(posedge sck_in or posedge frame_rst) begin
      if (frame_rst) begin
         bit_r <= 3'h0;
         shift_r <= 7'h00;
      end else begin
         bit_r <= bit_r + 3'h1;
         shift_r <= rx_byte[6:0];
      end
   end

   // ----------------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------------
   // Chooses the next state and the register updates of this edge
   always_comb begin
      state_nxt = state_r;
      dkind_nxt = dkind_r;
      tx_load = 1'b0;
      tx_nxt = 8'h00;
      wip_we = '0;
      slot_we = '0;
      slot_sel = rslot;
      nv_req = 1'b0;
      for (int i = 0; i < NCH; i++) begin
         wip_wd[i] = wiper_r[i];
         slot_wd[i] = wiper_r[i];
      end
      unique case (state_r)
         QPSD_ST_ID: begin
            if (byte_done) begin
               // Type code, zero pair and matching address
               if (rx_byte[7:4] == `QPSD_ID_TYPE && rx_byte[3:2] == `QPSD_ID_ZERO
                   && rx_byte[1:0] == addr_sync_r) begin
                  state_nxt = QPSD_ST_INSTR;
               end else begin
                  state_nxt = QPSD_ST_IGNORE;
               end
            end
         end
         QPSD_ST_INSTR: begin
            if (byte_done) begin
               state_nxt = QPSD_ST_DONE;
               unique case (rx_byte[7:4])
                  `QPSD_OP_RD_WIPER: begin
                     if (rx_slot == `QPSD_ZERO_SLOT) begin
                        tx_load = 1'b1;
                        tx_nxt = wiper_r[rx_chan];
                        dkind_nxt = QPSD_DK_READ;
                        state_nxt = QPSD_ST_DATA;
                     end
                  end
                  `QPSD_OP_WR_WIPER: begin
                     if (rx_slot == `QPSD_ZERO_SLOT) begin
                        dkind_nxt = QPSD_DK_WR_WIPER;
                        state_nxt = QPSD_ST_DATA;
                     end
                  end
                  `QPSD_OP_RD_SLOT: begin
                     tx_load = 1'b1;
                     tx_nxt = slot_r[{rx_chan, rx_slot}];
                     dkind_nxt = QPSD_DK_READ;
                     state_nxt = QPSD_ST_DATA;
                  end
                  `QPSD_OP_WR_SLOT: begin
                     dkind_nxt = QPSD_DK_WR_SLOT;
                     state_nxt = QPSD_ST_DATA;
                  end
                  `QPSD_OP_STATUS: begin
                     if (rx_byte[3:0] == `QPSD_STATUS_LOW) begin
                        tx_load = 1'b1;
                        tx_nxt = {`QPSD_STATUS_PAD, busy_sync_r};
                        dkind_nxt = QPSD_DK_READ;
                        state_nxt = QPSD_ST_DATA;
                     end
                  end
                  `QPSD_OP_GLB_SLOT_TO_WIPER: begin
                     if (rx_chan == `QPSD_ZERO_CHAN) begin
                        for (int i = 0; i < NCH; i++) begin
                           wip_we[i] = 1'b1;
                           wip_wd[i] = slot_r[{i[1:0], rx_slot}];
                        end
                     end
                  end
                  `QPSD_OP_GLB_WIPER_TO_SLOT: begin
                     if (rx_chan == `QPSD_ZERO_CHAN) begin
                        slot_we = '1;
                        slot_sel = rx_slot;
                        nv_req = 1'b1;
                     end
                  end
                  `QPSD_OP_WIPER_TO_SLOT: begin
                     slot_we[rx_chan] = 1'b1;
                     slot_sel = rx_slot;
                     nv_req = 1'b1;
                  end
                  `QPSD_OP_SLOT_TO_WIPER: begin
                     wip_we[rx_chan] = 1'b1;
                     wip_wd[rx_chan] = slot_r[{rx_chan, rx_slot}];
                  end
                  `QPSD_OP_STEP: begin
                     if (rx_slot == `QPSD_ZERO_SLOT) begin
                        state_nxt = QPSD_ST_STEP;
                     end
                  end
                  default: begin
                     // Unknown opcode: the rest of the frame is ignored
                     state_nxt = QPSD_ST_DONE;
                  end
               endcase
            end
         end
         QPSD_ST_DATA: begin
            if (byte_done) begin
               state_nxt = QPSD_ST_DONE;
               if (dkind_r == QPSD_DK_WR_WIPER) begin
                  wip_we[chan] = 1'b1;
                  wip_wd[chan] = rx_byte;
               end else if (dkind_r == QPSD_DK_WR_SLOT) begin
                  slot_we[chan] = 1'b1;
                  slot_wd[chan] = rx_byte;
                  nv_req = 1'b1;
               end
            end
         end
         QPSD_ST_STEP: begin
            // Every clock of the session moves the wiper one step unless it already sits at that end
            wip_we[chan] = 1'b1;
            if (si_in) begin
               if (wiper_r[chan] != `QPSD_WIPER_MAX) begin
                  wip_wd[chan] = wiper_r[chan] + 8'h01;
               end
            end else begin
               if (wiper_r[chan] != `QPSD_WIPER_MIN) begin
                  wip_wd[chan] = wiper_r[chan] - 8'h01;
               end
            end
         end
         QPSD_ST_IGNORE: begin
            // Stay silent until chip select rises
            state_nxt = QPSD_ST_IGNORE;
         end
         QPSD_ST_DONE: begin
            // Extra clocks after a complete command are ignored
            state_nxt = QPSD_ST_DONE;
         end
         default: begin
            state_nxt = QPSD_ST_IGNORE;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Frame state
   // ----------------------------------------------------------------------
   // State and instruction restart with every frame
   always_ff @(posedge sck_in or posedge frame_rst) begin
      if (frame_rst) begin
         state_r <= QPSD_ST_ID;
         dkind_r <= QPSD_DK_READ;
         instr_r <= 8'h00;
      end else begin
         state_r <= state_nxt;
         dkind_r <= dkind_nxt;
         if (state_r == QPSD_ST_INSTR && byte_done) begin
            instr_r <= rx_byte;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Transmit shifter
   // ----------------------------------------------------------------------
   // Loaded after the instruction byte, shifted on each data bit
   always_ff @(posedge sck_in or posedge frame_rst) begin
      if (frame_rst) begin
         tx_r <= 8'h00;
      end else if (tx_load) begin
         tx_r <= tx_nxt;
      end else if (state_r == QPSD_ST_DATA) begin
         tx_r <= {tx_r[6:0], 1'b0};
      end
   end

   // Output changes on the falling edge so the master samples it stable
   always_ff @(negedge sck_in or posedge frame_rst) begin
      if (frame_rst) begin
         so_r <= 1'b0;
         so_oe_r <= 1'b0;
      end else begin
         so_r <= tx_r[7];
         so_oe_r <= (state_r == QPSD_ST_DATA) && (dkind_r == QPSD_DK_READ);
      end
   end

   assign so_out = so_r;
   assign so_oe_out = so_oe_r;

   // ----------------------------------------------------------------------
   // Nonvolatile write request
   // ----------------------------------------------------------------------
   // A toggle carries each completed write sequence to the timer
   always_ff @(posedge sck_in or posedge rst_in) begin
      if (rst_in) begin
         nv_req_tgl_r <= 1'b0;
      end else if (nv_req) begin
         nv_req_tgl_r <= ~nv_req_tgl_r;
      end
   end

   // ----------------------------------------------------------------------
   // Wiper and slot storage, one generate per channel
   // ----------------------------------------------------------------------
   for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
      // Wiper position of this channel
      always_ff @(posedge sck_in or posedge rst_in) begin
         if (rst_in) begin
            wiper_r[ch] <= `QPSD_WIPER_RST;
         end else if (wip_we[ch]) begin
            wiper_r[ch] <= wip_wd[ch];
         end
      end

      // Saved setting slots of this channel
      for (genvar s = 0; s < 4; s++) begin : g_slot
         always_ff @(posedge sck_in or posedge rst_in) begin
            if (rst_in) begin
               slot_r[ch*4+s] <= `QPSD_SLOT_RST;
            end else if (slot_we[ch] && slot_sel == 2'(s)) begin
               slot_r[ch*4+s] <= slot_wd[ch];
            end
         end
      end

      assign wiper_position_reg_out[ch*8 +: 8] = wiper_r[ch];
   end

   // ----------------------------------------------------------------------
   // Write cycle timer on the system clock
   // ----------------------------------------------------------------------
   qpsd_nv_timer #(
      .NV_WRITE_CYCLES(NV_WRITE_CYCLES)
   ) u_timer (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .cs_n_in(cs_n_in),
      .req_tgl_in(nv_req_tgl_r),
      .busy_out(busy)
   );

   assign nv_write_busy_out = busy;

endmodule

// >>> test/qpsd_spi_master.sv
// Serial bus master model that frames commands into the decoder
module qpsd_spi_master (
   // Serial link toward the device
   output logic sck_out,
   output logic cs_n_out,
   output logic si_out,
   // Device answer
   input wire logic so_in,
   input wire logic so_oe_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // Clock stands low and select stays high between frames
   initial begin
      sck_out = 1'b0;
      cs_n_out = 1'b1;
      si_out = 1'b0;
   end
   // One frame of n bits, MSB first; third byte captured on rises 17 to 24
   task automatic frame(input logic [31:0] tx, input int n, output logic [7:0] rx,
      output logic oe);
      rx = 8'h00;
      oe = 1'b0;
      cs_n_out = 1'b0;
      for (int i = 0; i < n; i++) begin
         si_out = tx[n-1-i];
         #7.5 sck_out = 1'b1;
         if (i >= 16 && i < 24) begin
            rx = {rx[6:0], so_in};
            oe = oe | so_oe_in;
         end
         #7.5 sck_out = 1'b0;
      end
      #7.5 cs_n_out = 1'b1;
      si_out = ~si_out; // Released line shows the inverse of the last bit
      #15;
   endtask
endmodule

// >>> test/qpsd_spi_decoder_properties.sv
// Port checker of the serial command decoder
module qpsd_spi_decoder_chk #(
   parameter int unsigned NCH = 4,
   parameter int unsigned NV_WRITE_CYCLES = 100
) (
   // Clocks, reset and link
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic sck_in,
   input wire logic cs_n_in,
   input wire logic si_in,
   input wire logic so_out,
   input wire logic so_oe_out,
   // Straps and state
   input wire logic chip_addr_hi_in,
   input wire logic chip_addr_lo_in,
   input wire logic [NCH*8-1:0] wiper_position_reg_out,
   input wire logic nv_write_busy_out
);
   logic [5:0] cnt_r; // Rising edges seen in the frame
   logic [15:0] hdr_r; // Identification and instruction bytes
   logic [7:0] dat_r; // Bits after the instruction
   logic [31:0] bcnt_r; // Cycles of the running write
   logic [1:0] ch; // Selected channel
   logic id_ok; // Identification byte matches
   logic [NCH*8-1:0] up_w, dn_w, wr_w; // Expected wiper buses
   // Frame shadow, cleared while select is high
   always_ff @(posedge sck_in or posedge cs_n_in or posedge rst_in) begin
      if (rst_in || cs_n_in) begin
         cnt_r <= 6'h00;
         hdr_r <= 16'h0000;
         dat_r <= 8'h00;
      end else begin
         cnt_r <= (cnt_r == 6'h3f) ? cnt_r : cnt_r + 6'h01;
         if (cnt_r < 6'h10) hdr_r <= {hdr_r[14:0], si_in};
         else dat_r <= {dat_r[6:0], si_in};
      end
   end
   // Length of the busy pulse
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) bcnt_r <= 32'h0;
      else bcnt_r <= nv_write_busy_out ? bcnt_r + 32'h1 : 32'h0;
   end
   assign ch = hdr_r[1:0];
   assign id_ok = hdr_r[15:8] == {4'h5, 2'h0, chip_addr_hi_in, chip_addr_lo_in};
   // Expected buses after a step or a write of the selected channel
   always_comb begin
      up_w = wiper_position_reg_out;
      dn_w = wiper_position_reg_out;
      wr_w = wiper_position_reg_out;
      if (up_w[ch*8+:8] != 8'hff) up_w[ch*8+:8] = up_w[ch*8+:8] + 8'h01;
      if (dn_w[ch*8+:8] != 8'h00) dn_w[ch*8+:8] = dn_w[ch*8+:8] - 8'h01;
      wr_w[ch*8+:8] = {dat_r[6:0], si_in};
   end
   a_oe_cs_high: assert property (@(posedge clk_in) disable iff (rst_in)
      cs_n_in |-> !so_oe_out) else $error("oe while deselected");
   a_so_idle_low: assert property (@(posedge clk_in) disable iff (rst_in)
      !so_oe_out |-> !so_out) else $error("output not released");
   a_busy_len_max: assert property (@(posedge clk_in) disable iff (rst_in)
      bcnt_r <= NV_WRITE_CYCLES) else $error("write cycle too long");
   a_busy_len_min: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(nv_write_busy_out) |-> nv_write_busy_out [*8]) else $error("busy pulse short");
   a_busy_start_cs: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(nv_write_busy_out) |-> $past(cs_n_in)) else $error("write in frame");
   a_oe_window: assert property (@(posedge sck_in) disable iff (rst_in)
      so_oe_out |-> id_ok && cnt_r >= 6'h10 && cnt_r <= 6'h17) else $error("oe out of place");
   a_read_wiper: assert property (@(posedge sck_in) disable iff (rst_in)
      so_oe_out && hdr_r[7:4] == 4'h9 |-> so_out == wiper_position_reg_out[ch*8+7-cnt_r[2:0]])
      else $error("wiper read bit wrong");
   a_write_wiper: assert property (@(posedge sck_in) disable iff (rst_in)
      id_ok && hdr_r[7:2] == 6'h28 && cnt_r == 6'h17 |=> wiper_position_reg_out == $past(wr_w))
      else $error("wiper write wrong");
   a_step_up: assert property (@(posedge sck_in) disable iff (rst_in)
      id_ok && hdr_r[7:2] == 6'h08 && cnt_r >= 6'h10 && si_in
      |=> wiper_position_reg_out == $past(up_w)) else $error("step up wrong");
   a_step_down: assert property (@(posedge sck_in) disable iff (rst_in)
      id_ok && hdr_r[7:2] == 6'h08 && cnt_r >= 6'h10 && !si_in
      |=> wiper_position_reg_out == $past(dn_w)) else $error("step down wrong");
endmodule
bind qpsd_spi_decoder qpsd_spi_decoder_chk #(.NCH(NCH), .NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_chk (
   .clk_in(clk_in), .rst_in(rst_in), .sck_in(sck_in), .cs_n_in(cs_n_in), .si_in(si_in),
   .so_out(so_out), .so_oe_out(so_oe_out), .chip_addr_hi_in(chip_addr_hi_in),
   .chip_addr_lo_in(chip_addr_lo_in), .wiper_position_reg_out(wiper_position_reg_out),
   .nv_write_busy_out(nv_write_busy_out));

// >>> test/qpsd_spi_decoder_tb_top.sv
// Self-checking bench of the serial command decoder
`include "qpsd_cfg.svh"
module qpsd_spi_decoder_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_in, rst_in, sck, cs_n, si, so, so_oe, ahi, alo, busy, oe;
   logic [31:0] write_status; // Wiper bus
   logic [7:0] rx, d, idv; // Read byte, data, id byte in use
   logic [7:0] w [4]; // Expected wipers
   logic [7:0] s [4][4]; // Expected slots by slot and channel
   logic [1:0] adr, sl, c;
   int miscompares = 0;
   int check_count = 0;
   qpsd_spi_decoder #(.NV_WRITE_CYCLES(100)) DUT (.clk_in(clk_in), .rst_in(rst_in),
      .sck_in(sck), .cs_n_in(cs_n), .si_in(si), .so_out(so), .so_oe_out(so_oe),
      .chip_addr_hi_in(ahi), .chip_addr_lo_in(alo), .wiper_position_reg_out(write_status),
      .nv_write_busy_out(busy));
   qpsd_spi_master u_master (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so),
      .so_oe_in(so_oe));
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // Expected wiper after one step, held at the ends
   function automatic logic [7:0] stepv(input logic [7:0] v, input logic up);
      if (up) return (v == `QPSD_WIPER_MAX) ? v : v + 8'h01;
      return (v == `QPSD_WIPER_MIN) ? v : v - 8'h01;
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One command of n bits with the current id byte
   task automatic xf(input logic [3:0] op, input logic [1:0] r, input logic [1:0] p,
      input logic [7:0] dd, input int n);
      u_master.frame({8'h00, idv, op, r, p, dd} >> (24 - n), n, rx, oe);
   endtask
   task automatic chkw();
      for (int k = 0; k < 4; k++) check("wiper", write_status[k*8+:8], w[k]);
   endtask
   // Busy rises, status reads one, then busy falls and status reads zero
   task automatic nvwait();
      for (int k = 0; k < 40 && busy !== 1'b1; k++) @(negedge clk_in);
      check("busy_hi", busy, 1);
      xf(`QPSD_OP_STATUS, 2'h0, 2'h1, 8'h00, 24);
      check("status_busy", rx, 8'h01);
      for (int k = 0; k < 200 && busy !== 1'b0; k++) @(negedge clk_in);
      check("busy_lo", busy, 0);
      xf(`QPSD_OP_STATUS, 2'h0, 2'h1, 8'h00, 24);
      check("status_idle", rx, 8'h00);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #300000;
      miscompares++;
      results();
   end
   initial begin
      rst_in = 1'b1;
      void'($urandom(82));
      adr = 2'($urandom);
      {ahi, alo} = adr;
      idv = {`QPSD_ID_TYPE, `QPSD_ID_ZERO, adr};
      foreach (s[i, j]) s[i][j] = 8'h00;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in) rst_in = 1'b0;
      check("wip_rst", write_status, 32'h0);
      check("busy_rst", busy, 0);
      // Wiper write then read back on every channel
      for (int k = 0; k < 4; k++) begin
         w[k] = 8'($urandom);
         xf(`QPSD_OP_WR_WIPER, 2'h0, 2'(k), w[k], 24);
      end
      chkw();
      for (int k = 0; k < 4; k++) begin
         xf(`QPSD_OP_RD_WIPER, 2'h0, 2'(k), 8'h00, 24);
         check("rd_wiper", {oe, rx}, {1'b1, w[k]});
      end
      $display("wiper test done");
      // Slot writes with write cycle, then reads
      for (int k = 0; k < 3; k++) begin
         {sl, c, d} = 12'($urandom);
         s[sl][c] = d;
         xf(`QPSD_OP_WR_SLOT, sl, c, d, 24);
         nvwait();
         xf(`QPSD_OP_RD_SLOT, sl, c, 8'h00, 24);
         check("rd_slot", rx, s[sl][c]);
      end
      // Single recall and save
      xf(`QPSD_OP_SLOT_TO_WIPER, sl, c, 8'h00, 16);
      w[c] = s[sl][c];
      chkw();
      sl = sl + 2'h1;
      s[sl][c] = w[c];
      xf(`QPSD_OP_WIPER_TO_SLOT, sl, c, 8'h00, 16);
      nvwait();
      xf(`QPSD_OP_RD_SLOT, sl, c, 8'h00, 24);
      check("save_one", rx, s[sl][c]);
      // Global save, scramble wipers, global recall
      xf(`QPSD_OP_GLB_WIPER_TO_SLOT, sl, 2'h0, 8'h00, 16);
      nvwait();
      for (int k = 0; k < 4; k++) xf(`QPSD_OP_WR_WIPER, 2'h0, 2'(k), ~w[k], 24);
      xf(`QPSD_OP_GLB_SLOT_TO_WIPER, sl, 2'h0, 8'h00, 16);
      chkw();
      $display("slot test done");
      // Step sessions near full scale, near zero and random
      for (int t = 0; t < 4; t++) begin
         c = 2'($urandom);
         d = (t == 0) ? 8'hfd : (t == 1) ? 8'h02 : 8'($urandom);
         rx = (t == 0) ? 8'hff : (t == 1) ? 8'h00 : 8'($urandom);
         xf(`QPSD_OP_WR_WIPER, 2'h0, c, d, 24);
         w[c] = d;
         for (int k = 0; k < 6; k++) w[c] = stepv(w[c], rx[7-k]);
         xf(`QPSD_OP_STEP, 2'h0, c, rx, 22);
         chkw();
      end
      $display("step test done");
      // Bad address, bad type and nonzero fixed bits are ignored
      for (int t = 0; t < 3; t++) begin
         idv = (t == 0) ? {4'h5, 2'h0, ~adr} : (t == 1) ? {4'h6, 2'h0, adr} : {4'h5, 2'h1, adr};
         xf(`QPSD_OP_WR_WIPER, 2'h0, 2'h0, ~w[0], 24);
         xf(`QPSD_OP_RD_WIPER, 2'h0, 2'h0, 8'h00, 24);
         check("bad_id_oe", oe, 0);
         chkw();
      end
      $display("id test done");
      results();
   end
endmodule
